// *** bench/acr_regs_chk.sv ***
// assertion checker for the chop and channel 0 register slice
`timescale 1ns/10ps
`default_nettype none
module acr_regs_chk #(
	parameter CLK_PERIOD_NS = 25,
	parameter CHOP_UNIT_NS = 400
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic CONV_DONE_I,
	input wire logic DATA_VALID_O,
	input wire logic CHOP_EN_O,
	input wire logic CHOP_SWAP_O,
	input wire logic CONV_HOLD_O,
	input wire logic [1:0] INPUT_SEL_O,
	input wire logic PIN_CONNECT_O,
	input wire logic INPUT_SHORT_O,
	input wire logic TEST_POS_O,
	input wire logic TEST_NEG_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wr_chop;
		WR_I && ADDR_I == 8'h06;
	endsequence
	sequence s_accept;
		CONV_DONE_I && !CONV_HOLD_O;
	endsequence
	property p_chop_en;
		s_wr_chop |=> ##1 CHOP_EN_O == $past(WDATA_I[8], 2);
	endproperty
	property p_rsv;
		RD_I && ADDR_I == 8'h08 |=> RDATA_O[7:4] == 4'h0;
	endproperty
	property p_cfg;
		RD_I && ADDR_I == 8'h09 |=> RDATA_O[5:3] == 3'h0;
	endproperty
	property p_lsb;
		RD_I && (ADDR_I == 8'h0B || ADDR_I == 8'h0D) |=> RDATA_O[7:0] == 8'h00;
	endproperty
	property p_sel;
		{TEST_NEG_O, TEST_POS_O, INPUT_SHORT_O, PIN_CONNECT_O}
			== 4'h1 << INPUT_SEL_O;
	endproperty
	property p_valid;
		s_accept |=> DATA_VALID_O;
	endproperty
	property p_drop;
		DATA_VALID_O |-> $past(CONV_DONE_I) && !$past(CONV_HOLD_O);
	endproperty
	property p_swap;
		s_accept ##0 (CHOP_EN_O && !$past(WR_I))
			|=> CONV_HOLD_O && CHOP_SWAP_O != $past(CHOP_SWAP_O);
	endproperty
	property p_off;
		!CHOP_EN_O && !$past(CHOP_EN_O) |-> !CHOP_SWAP_O && !CONV_HOLD_O;
	endproperty
	a_chop_en: assert property (p_chop_en) else $error("chop enable");
	a_rsv: assert property (p_rsv) else $error("reg 08 bits");
	a_cfg: assert property (p_cfg) else $error("reg 09 bits");
	a_lsb: assert property (p_lsb) else $error("low byte");
	a_sel: assert property (p_sel) else $error("input decode");
	a_valid: assert property (p_valid) else $error("no valid");
	a_drop: assert property (p_drop) else $error("stray valid");
	a_swap: assert property (p_swap) else $error("no swap");
	a_off: assert property (p_off) else $error("chop off");
endmodule
bind acr_regs acr_regs_chk #(.CLK_PERIOD_NS(CLK_PERIOD_NS),
	.CHOP_UNIT_NS(CHOP_UNIT_NS)) acr_regs_chk_i (.CLK_I(CLK_I),
	.RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .RDATA_O(RDATA_O), .CONV_DONE_I(CONV_DONE_I),
	.DATA_VALID_O(DATA_VALID_O), .CHOP_EN_O(CHOP_EN_O),
	.CHOP_SWAP_O(CHOP_SWAP_O), .CONV_HOLD_O(CONV_HOLD_O),
	.INPUT_SEL_O(INPUT_SEL_O), .PIN_CONNECT_O(PIN_CONNECT_O),
	.INPUT_SHORT_O(INPUT_SHORT_O), .TEST_POS_O(TEST_POS_O),
	.TEST_NEG_O(TEST_NEG_O));
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the chop and channel 0 register slice
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic done = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [23:0] raw = 24'h000000;
	wire [15:0] rdata;
	wire [23:0] dout;
	wire [1:0] sel;
	wire dval, cen, swp, hold, pc, sh, tp, tn;
	int err_count = 0;
	int n_compared = 0;
	logic [15:0] rst_v [8] = '{16'h0600, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h8000, 16'h0000};
	// write patterns set read-only reserved bits to one
	logic [15:0] wr_v [8] = '{16'h1F00, 16'h0000, 16'h00F0, 16'h003B,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	logic [15:0] msk_v [8] = '{16'h1F00, 16'h0000, 16'h0000, 16'h0003,
		16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
	logic [23:0] c_off [5] = '{24'h123456, 24'hFFFFF0, 24'h000000,
		24'h000000, 24'h7FFFFF};
	logic [23:0] c_gain [5] = '{24'h800000, 24'h800000, 24'h400001,
		24'hFFFFFF, 24'h800000};
	logic [23:0] c_raw [5] = '{24'h200000, 24'h000000, 24'h7FFFFE,
		24'h7FFFFF, 24'h800000};
	always #12.5 clk = ~clk;
	acr_regs #(.CHOP_UNIT_NS(25)) acr_regs_i (.CLK_I(clk), .RST_I(rst),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .RAW_DATA_I(raw), .CONV_DONE_I(done),
		.DATA_O(dout), .DATA_VALID_O(dval), .CHOP_EN_O(cen),
		.CHOP_SWAP_O(swp), .CONV_HOLD_O(hold), .INPUT_SEL_O(sel),
		.PIN_CONNECT_O(pc), .INPUT_SHORT_O(sh), .TEST_POS_O(tp),
		.TEST_NEG_O(tn));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	task automatic conv(input logic [23:0] r, input logic [23:0] exp);
		@(posedge clk);
		done <= 1'b1;
		raw <= r;
		@(posedge clk);
		done <= 1'b0;
		@(negedge clk);
		chk(dval, 1'b1);
		chk(dout, exp);
	endtask
	function automatic logic [23:0] cal(input logic [23:0] r, o, g);
		longint v;
		v = (longint'($signed(r)) - longint'($signed(o))) * longint'(g);
		v = v >>> 23;
		if (v > 64'sh7FFFFF)
			return 24'h7FFFFF;
		if (v < -64'sh800000)
			return 24'h800000;
		return v[23:0];
	endfunction
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] a;
		int i;
		int n;
		logic [23:0] e;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (a = 8'h06; a <= 8'h0D; a++)
			rd_chk(a, rst_v[a - 8'h06]);
		rd_chk(8'h05, 16'h0000);
		$display("test reset done");
		for (a = 8'h06; a <= 8'h0D; a++) begin
			wr_reg(a, wr_v[a - 8'h06]);
			rd_chk(a, msk_v[a - 8'h06]);
		end
		for (a = 8'h06; a <= 8'h0D; a++)
			wr_reg(a, rst_v[a - 8'h06]);
		wr_reg(8'h20, 16'hFFFF);
		rd_chk(8'h20, 16'h0000);
		$display("test access done");
		for (i = 0; i < 4; i++) begin
			wr_reg(8'h09, 16'(i));
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(sel, 24'(i));
			chk({tn, tp, sh, pc}, 24'(4'h1 << i));
		end
		wr_reg(8'h09, 16'h0000);
		$display("test select done");
		wr_reg(8'h06, 16'h0900);
		rd_chk(8'h06, 16'h0900);
		chk(cen, 1'b1);
		conv(24'h001000, 24'h001000);
		chk(swp, 1'b1);
		n = 0;
		while (hold === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40) begin
			err_count++;
			results();
		end
		chk(24'(n), 24'h000005);
		conv(24'h001000, 24'hFFF000);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		@(negedge clk);
		chk(dval, 1'b0);
		wr_reg(8'h06, 16'h0600);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({cen, swp, hold}, 24'h0);
		$display("test chop done");
		for (i = 0; i < 5; i++) begin
			wr_reg(8'h0A, c_off[i][23:8]);
			wr_reg(8'h0B, {c_off[i][7:0], 8'h00});
			wr_reg(8'h0C, c_gain[i][23:8]);
			wr_reg(8'h0D, {c_gain[i][7:0], 8'h00});
			e = cal(c_raw[i], c_off[i], c_gain[i]);
			conv(c_raw[i], e);
		end
		$display("test calibration done");
		results();
	end
endmodule
`default_nettype wire

// *** rtl/acr_cal.v ***
// channel 0 offset subtract and gain scale with saturation
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.vh"

module acr_cal (
	input wire [24:0] raw_i,
	input wire [23:0] offset_i,
	input wire [23:0] gain_i,
	output reg [23:0] result_o
);

// ----------------------------------------------------------------
// arithmetic
// ----------------------------------------------------------------
wire signed [25:0] raw_s = {raw_i[24], raw_i};
// offset is two's complement
wire signed [25:0] off_s = {{2{offset_i[23]}}, offset_i};
wire signed [25:0] diff = raw_s - off_s;
// gain is unsigned, unity at 2^23
wire signed [24:0] gain_s = {1'b0, gain_i};
wire signed [50:0] prod = diff * gain_s;
wire signed [50:0] scaled = prod >>> `ACR_GAIN_FRAC;
wire signed [50:0] pos_full = 51'sh7FFFFF;
wire signed [50:0] neg_full = -51'sh800000;

// ----------------------------------------------------------------
// saturation at full scale
// ----------------------------------------------------------------
always @* begin
	if (scaled > pos_full) begin
		result_o = 24'h7FFFFF;
	end else if (scaled < neg_full) begin
		result_o = 24'h800000;
	end else begin
		result_o = scaled[23:0];
	end
end

endmodule
`default_nettype wire

// *** rtl/acr_defines.vh ***
// constants for the chop and channel 0 calibration register slice
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACR_ADDR_W 8
`define ACR_ADDR_CHOP 8'h06
`define ACR_ADDR_RSVA 8'h07
`define ACR_ADDR_RSVB 8'h08
`define ACR_ADDR_CH0CFG 8'h09
`define ACR_ADDR_OMSB 8'h0A
`define ACR_ADDR_OLSB 8'h0B
`define ACR_ADDR_GMSB 8'h0C
`define ACR_ADDR_GLSB 8'h0D
`define ACR_ADDR_FIRST `ACR_ADDR_CHOP
`define ACR_ADDR_LAST `ACR_ADDR_GLSB

// ----------------------------------------------------------------
// storage indices (offset minus first offset)
// ----------------------------------------------------------------
`define ACR_NUM_REGS 8
`define ACR_IDX_CHOP 3'h0
`define ACR_IDX_RSVA 3'h1
`define ACR_IDX_RSVB 3'h2
`define ACR_IDX_CH0CFG 3'h3
`define ACR_IDX_OMSB 3'h4
`define ACR_IDX_OLSB 3'h5
`define ACR_IDX_GMSB 3'h6
`define ACR_IDX_GLSB 3'h7

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define ACR_RST_CHOP 16'h0600
`define ACR_RST_GMSB 16'h8000
`define ACR_RST_ZERO 16'h0000
`define ACR_MASK_ALL 16'hFFFF
`define ACR_MASK_RSVB 16'hFF0F
`define ACR_MASK_CH0CFG 16'hFFC7
`define ACR_MASK_LSB 16'hFF00

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ACR_CHOP_EN_BIT 8
`define ACR_CHOP_DLY_MSB 12
`define ACR_CHOP_DLY_LSB 9
`define ACR_MUX_MSB 1
`define ACR_MUX_LSB 0
`define ACR_LOW_BYTE_MSB 15
`define ACR_LOW_BYTE_LSB 8
`define ACR_MUX_PINS 2'h0
`define ACR_MUX_SHORT 2'h1
`define ACR_MUX_TEST_POS 2'h2
`define ACR_MUX_TEST_NEG 2'h3

// ----------------------------------------------------------------
// data path and timing
// ----------------------------------------------------------------
`define ACR_GAIN_FRAC 23
`define ACR_CLK_PERIOD_NS 25
`define ACR_CHOP_UNIT_NS 400

`endif

// *** rtl/acr_regs.v ***
// register slice: global chop configuration and channel 0 calibration
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.vh"

module acr_regs #(
	parameter CLK_PERIOD_NS = `ACR_CLK_PERIOD_NS,
	parameter CHOP_UNIT_NS = `ACR_CHOP_UNIT_NS
) (
	input wire CLK_I,
	input wire RST_I,
	input wire [7:0] ADDR_I,
	input wire [15:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [15:0] RDATA_O,
	input wire [23:0] RAW_DATA_I,
	input wire CONV_DONE_I,
	output reg [23:0] DATA_O,
	output reg DATA_VALID_O,
	output reg CHOP_EN_O,
	output reg CHOP_SWAP_O,
	output reg CONV_HOLD_O,
	output reg [1:0] INPUT_SEL_O,
	output reg PIN_CONNECT_O,
	output reg INPUT_SHORT_O,
	output reg TEST_POS_O,
	output reg TEST_NEG_O
);

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
localparam integer UNIT_CYC_RAW =
	(CHOP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
localparam integer UNIT_CYC = (UNIT_CYC_RAW < 1) ? 1 : UNIT_CYC_RAW;
localparam [15:0] UNIT_CYC_W = UNIT_CYC[15:0];

localparam ST_RUN = 1'b0;
localparam ST_SETTLE = 1'b1;

// ----------------------------------------------------------------
// decoding helpers
// ----------------------------------------------------------------
function [15:0] acr_mask;
	input [2:0] idx;
	begin
		case (idx)
			`ACR_IDX_RSVB: begin
				acr_mask = `ACR_MASK_RSVB;
			end
			`ACR_IDX_CH0CFG: begin
				acr_mask = `ACR_MASK_CH0CFG;
			end
			`ACR_IDX_OLSB, `ACR_IDX_GLSB: begin
				acr_mask = `ACR_MASK_LSB;
			end
			default: begin
				acr_mask = `ACR_MASK_ALL;
			end
		endcase
	end
endfunction

function [15:0] acr_reset_val;
	input [2:0] idx;
	begin
		case (idx)
			`ACR_IDX_CHOP: begin
				acr_reset_val = `ACR_RST_CHOP;
			end
			`ACR_IDX_GMSB: begin
				acr_reset_val = `ACR_RST_GMSB;
			end
			default: begin
				acr_reset_val = `ACR_RST_ZERO;
			end
		endcase
	end
endfunction

function in_map;
	input [7:0] addr;
	begin
		in_map = (addr >= `ACR_ADDR_FIRST) && (addr <= `ACR_ADDR_LAST);
	end
endfunction

// one-hot view of the channel 0 input select
function [3:0] acr_sel_hot;
	input [1:0] sel;
	begin
		case (sel)
			`ACR_MUX_SHORT: begin
				acr_sel_hot = 4'h2;
			end
			`ACR_MUX_TEST_POS: begin
				acr_sel_hot = 4'h4;
			end
			`ACR_MUX_TEST_NEG: begin
				acr_sel_hot = 4'h8;
			end
			default: begin
				acr_sel_hot = 4'h1;
			end
		endcase
	end
endfunction

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
reg [15:0] regs_ff [0:`ACR_NUM_REGS-1];
wire [7:0] addr_off = ADDR_I - `ACR_ADDR_FIRST;
wire [2:0] acc_idx = addr_off[2:0];
wire wr_hit = WR_I && in_map(ADDR_I);
wire rd_hit = RD_I && in_map(ADDR_I);

genvar g;
generate
	for (g = 0; g < `ACR_NUM_REGS; g = g + 1) begin : gen_reg
		localparam [31:0] IDX_W = g;
		localparam [2:0] IDX = IDX_W[2:0];
		always @(posedge CLK_I) begin
			if (RST_I) begin
				regs_ff[g] <= acr_reset_val(IDX);
			end else if (wr_hit && (acc_idx == IDX)) begin
				// read-only reserved bits never store
				regs_ff[g] <= WDATA_I & acr_mask(IDX);
			end
		end
	end
endgenerate

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
wire [15:0] chop_reg = regs_ff[`ACR_IDX_CHOP];
wire [15:0] cfg_reg = regs_ff[`ACR_IDX_CH0CFG];
wire chop_enable = chop_reg[`ACR_CHOP_EN_BIT];
wire [3:0] chop_settle_delay =
	chop_reg[`ACR_CHOP_DLY_MSB:`ACR_CHOP_DLY_LSB];
wire [1:0] ch0_input_select =
	cfg_reg[`ACR_MUX_MSB:`ACR_MUX_LSB];
wire [15:0] ch0_offset_high_word = regs_ff[`ACR_IDX_OMSB];
wire [7:0] ch0_offset_low_byte =
	regs_ff[`ACR_IDX_OLSB][`ACR_LOW_BYTE_MSB:`ACR_LOW_BYTE_LSB];
wire [15:0] ch0_gain_high_word = regs_ff[`ACR_IDX_GMSB];
wire [7:0] ch0_gain_low_byte =
	regs_ff[`ACR_IDX_GLSB][`ACR_LOW_BYTE_MSB:`ACR_LOW_BYTE_LSB];

wire [23:0] offset_word =
	{ch0_offset_high_word, ch0_offset_low_byte};
wire [23:0] gain_word =
	{ch0_gain_high_word, ch0_gain_low_byte};

// ----------------------------------------------------------------
// register read port
// ----------------------------------------------------------------
always @(posedge CLK_I) begin
	if (RST_I) begin
		RDATA_O <= 16'h0000;
	end else if (rd_hit) begin
		RDATA_O <= regs_ff[acc_idx] & acr_mask(acc_idx);
	end else begin
		RDATA_O <= 16'h0000;
	end
end

// ----------------------------------------------------------------
// input selection
// ----------------------------------------------------------------
wire [3:0] sel_hot = acr_sel_hot(ch0_input_select);

always @(posedge CLK_I) begin
	if (RST_I) begin
		INPUT_SEL_O <= `ACR_MUX_PINS;
		PIN_CONNECT_O <= 1'b1;
		INPUT_SHORT_O <= 1'b0;
		TEST_POS_O <= 1'b0;
		TEST_NEG_O <= 1'b0;
	end else begin
		INPUT_SEL_O <= ch0_input_select;
		PIN_CONNECT_O <= sel_hot[0];
		INPUT_SHORT_O <= sel_hot[1];
		TEST_POS_O <= sel_hot[2];
		TEST_NEG_O <= sel_hot[3];
	end
end

// ----------------------------------------------------------------
// chop sequencer
// ----------------------------------------------------------------
reg state_ff;
reg nxt_state;
reg swap_ff;
reg nxt_swap;
reg [15:0] settle_ff;
reg [15:0] nxt_settle;

wire accept = CONV_DONE_I && (state_ff == ST_RUN);
wire [15:0] settle_load =
	({12'h000, chop_settle_delay} + 16'h0001) * UNIT_CYC_W;

always @* begin
	nxt_state = state_ff;
	nxt_swap = swap_ff;
	nxt_settle = settle_ff;
	case (state_ff)
		ST_RUN: begin
			if (!chop_enable) begin
				nxt_swap = 1'b0;
			end else if (accept) begin
				// swap polarity, then wait before next result
				nxt_swap = ~swap_ff;
				nxt_settle = settle_load;
				nxt_state = ST_SETTLE;
			end
		end
		ST_SETTLE: begin
			if (!chop_enable) begin
				// leaving chop mode ends the settle at once
				nxt_swap = 1'b0;
				nxt_settle = 16'h0000;
				nxt_state = ST_RUN;
			end else if (settle_ff <= 16'h0001) begin
				nxt_settle = 16'h0000;
				nxt_state = ST_RUN;
			end else begin
				nxt_settle = settle_ff - 16'h0001;
			end
		end
		default: begin
			nxt_state = ST_RUN;
			nxt_swap = 1'b0;
			nxt_settle = 16'h0000;
		end
	endcase
end

always @(posedge CLK_I) begin
	if (RST_I) begin
		state_ff <= ST_RUN;
		swap_ff <= 1'b0;
		settle_ff <= 16'h0000;
	end else begin
		state_ff <= nxt_state;
		swap_ff <= nxt_swap;
		settle_ff <= nxt_settle;
	end
end

always @(posedge CLK_I) begin
	if (RST_I) begin
		CHOP_EN_O <= 1'b0;
		CHOP_SWAP_O <= 1'b0;
		CONV_HOLD_O <= 1'b0;
	end else begin
		CHOP_EN_O <= chop_enable;
		CHOP_SWAP_O <= nxt_swap;
		CONV_HOLD_O <= (nxt_state == ST_SETTLE);
	end
end

// ----------------------------------------------------------------
// calibrated data path
// ----------------------------------------------------------------
// swapped inputs give an inverted raw result; undo it first
wire [24:0] raw_ext = {RAW_DATA_I[23], RAW_DATA_I};
wire [24:0] raw_fix = swap_ff ? (25'h0000000 - raw_ext) : raw_ext;
wire [23:0] cal_out;

acr_cal acr_cal_i (
	.raw_i(raw_fix),
	.offset_i(offset_word),
	.gain_i(gain_word),
	.result_o(cal_out)
);

always @(posedge CLK_I) begin
	if (RST_I) begin
		DATA_O <= 24'h000000;
		DATA_VALID_O <= 1'b0;
	end else begin
		DATA_VALID_O <= accept;
		if (accept) begin
			DATA_O <= cal_out;
		end
	end
end

endmodule
`default_nettype wire
